// ==== lsa_pkg.sv ====
// Purpose: Shared sizes, factor limits and timing for the serial skew/alignment block.
// Assumes: Core clock of 125 MHz; forwarded clocks are sampled, not used as clocks.
// Notes:   Factors are 4-bit values; legal set is 1, 2 and 4..10.
package lsa_pkg;
  localparam int          CH_N       = 36;  // Receive and transmit channels each
  localparam int          GRP_N      = 2;   // Clock generators per direction
  localparam int          CH_PER_GRP = 18;  // Channels served by one generator
  localparam int          FW         = 4;   // Factor field width
  localparam int          DW         = 10;  // Widest parallel word
  localparam int          PW         = 8;   // Period/phase counter width
  localparam logic [3:0]  FACT_ONE   = 4'h1;
  localparam logic [3:0]  FACT_TWO   = 4'h2;
  localparam logic [3:0]  FACT_LO    = 4'h4;  // Lowest of the contiguous range
  localparam logic [3:0]  FACT_HI    = 4'ha;  // Highest factor
  localparam logic [7:0]  PER_MAX    = 8'hff; // Period counter saturation
  localparam int          CLK_NS     = 8;
  localparam int          TX_BIT_NS  = 16;    // Transmit bit time
  localparam int          TX_BIT_CYC = (TX_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  TX_DIV_END = 4'(TX_BIT_CYC - 1);
  typedef enum logic [0:0] {LSA_HUNT, LSA_LOCKED} lsa_lock_t;
endpackage : lsa_pkg

// ==== lsa_serdes.sv ====
// Purpose: Sampled-clock serializer/deserializer with per-channel skew correction and training alignment.
// Assumes: Forwarded clock period in core cycles is at least the multiply factor.
// Notes:   Config inputs come from core-clock logic and must be static while running.
// How it works
// RULE1: Every data channel travels with a forwarded slow clock, sent and sampled.
// RULE2: Receiver multiplies forwarded clock by factor 1, 2 or 4..10 for bit timing.
// RULE3: Deserialize factor is 1, 2 or 4..10 and may differ from multiply factor.
// RULE4: Parallel word is deserialize-factor bits wide, one word per that many bits.
// RULE5: Each receive channel has its own skew correction against the forwarded clock.
// RULE6: Single-bit mode corrects fixed skew up to half a bit period.
// RULE7: Single-bit mode needs equal deserialize and multiply factors, set by the user.
// RULE8: Training pattern is leading zeros then ones, e.g. 0000011111 or 0011.
// RULE9: Factor and received training pattern give word alignment without framing input; here only for factors 4..10.
// RULE10: Multi-bit mode corrects fixed skew of any size, beyond one bit.
// RULE11: Thirty-six receive and thirty-six transmit channels.
// RULE12: Two dedicated clock generators serve receivers, two serve transmitters.
// RULE13: Transmitter shifts words out MSB first, matching the training pattern order.
`timescale 1ns/100ps
`default_nettype none
module lsa_serdes (
  input  wire logic                                      clk_i,
  input  wire logic                                      reset_i,
  input  wire logic [3:0]                                mult_i,
  input  wire logic [3:0]                                deser_i,
  input  wire logic                                      multi_bit_i,
  input  wire logic                                      train_i,
  input  wire logic [lsa_pkg::GRP_N-1:0]                 rx_fclk_i,
  input  wire logic [lsa_pkg::CH_N-1:0]                  rx_data_i,
  output logic      [lsa_pkg::CH_N-1:0][lsa_pkg::DW-1:0] rx_word_o,
  output logic      [lsa_pkg::CH_N-1:0]                  rx_valid_o,
  output logic      [lsa_pkg::CH_N-1:0]                  rx_aligned_o,
  output logic      [lsa_pkg::GRP_N-1:0]                 rx_lock_o,
  output logic                                           cfg_err_o,
  input  wire logic [lsa_pkg::CH_N-1:0][lsa_pkg::DW-1:0] tx_word_i,
  output logic      [lsa_pkg::GRP_N-1:0]                 tx_take_o,
  output logic      [lsa_pkg::CH_N-1:0]                  tx_data_o,
  output logic      [lsa_pkg::GRP_N-1:0]                 tx_fclk_o
);
  // Factor legality check
  function automatic logic fact_ok(input logic [3:0] f);
    fact_ok = (f == lsa_pkg::FACT_ONE) || (f == lsa_pkg::FACT_TWO) ||
              ((f >= lsa_pkg::FACT_LO) && (f <= lsa_pkg::FACT_HI));
  endfunction : fact_ok

  // Training word as it sits in the low bits of the shift register
  function automatic logic [9:0] train_pat(input logic [3:0] j);
    train_pat = 10'((11'h1 << (j >> 1)) - 11'h1);
  endfunction : train_pat

  function automatic int grp_of(input int ch);
    grp_of = ch / lsa_pkg::CH_PER_GRP;
  endfunction : grp_of

  logic                                      cfg_bad;
  logic [lsa_pkg::GRP_N-1:0]                 fclk_s1, fclk_s2, fclk_s3;
  logic [lsa_pkg::CH_N-1:0]                  din_s1, din_s2, din_s3;
  logic [lsa_pkg::GRP_N-1:0][lsa_pkg::PW-1:0] per_cnt, per;
  lsa_pkg::lsa_lock_t                        lock_st [lsa_pkg::GRP_N];
  logic [lsa_pkg::GRP_N-1:0]                 frise;
  logic [lsa_pkg::CH_N-1:0][lsa_pkg::PW-1:0] acc;
  logic [lsa_pkg::CH_N-1:0][lsa_pkg::DW-1:0] sr;
  logic [lsa_pkg::CH_N-1:0][3:0]             bcnt;
  logic [lsa_pkg::CH_N-1:0]                  samp;
  logic [lsa_pkg::GRP_N-1:0][3:0]            tdiv, twcnt, tccnt;
  logic [lsa_pkg::CH_N-1:0][lsa_pkg::DW-1:0] tsr;

  // Illegal factors, or unequal factors in single-bit mode, idle the channels and transmitters; receive lock clears at the next forwarded-clock rise
  assign cfg_bad = !fact_ok(mult_i) || !fact_ok(deser_i) ||
                   (!multi_bit_i && (mult_i != deser_i));  // [RULE3] [RULE7]
  assign frise   = fclk_s2 & ~fclk_s3;

  always_ff @(posedge clk_i) begin
    cfg_err_o <= reset_i ? 1'b0 : cfg_bad;  // [RULE7]
  end

  // Pin synchronisers; third stage feeds edge detection and, on data lanes, the shift registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fclk_s1 <= '0;
      fclk_s2 <= '0;
      fclk_s3 <= '0;
      din_s1  <= '0;
      din_s2  <= '0;
      din_s3  <= '0;
    end else begin
      fclk_s1 <= rx_fclk_i;  // [RULE1]
      fclk_s2 <= fclk_s1;
      fclk_s3 <= fclk_s2;
      din_s1  <= rx_data_i;
      din_s2  <= din_s1;
      din_s3  <= din_s2;
    end
  end

  // Receive clock generators: measure forwarded period, lock when it repeats
  always_ff @(posedge clk_i) begin
    for (int g = 0; g < lsa_pkg::GRP_N; g++) begin  // [RULE12]
      if (reset_i) begin
        per_cnt[g]   <= '0;
        per[g]       <= '0;
        lock_st[g]   <= lsa_pkg::LSA_HUNT;
        rx_lock_o[g] <= 1'b0;
      end else if (frise[g]) begin
        per_cnt[g] <= '0;
        per[g]     <= per_cnt[g] + 8'h01;
        // Period must hold and leave room for the multiplied bit slots
        if ((per_cnt[g] + 8'h01 == per[g]) && (per[g] >= {4'h0, mult_i}) && !cfg_bad) begin  // [RULE2]
          lock_st[g]   <= lsa_pkg::LSA_LOCKED;
          rx_lock_o[g] <= 1'b1;
        end else begin
          lock_st[g]   <= lsa_pkg::LSA_HUNT;
          rx_lock_o[g] <= 1'b0;
        end
      end else if (per_cnt[g] != lsa_pkg::PER_MAX) begin
        per_cnt[g] <= per_cnt[g] + 8'h01;
      end else begin
        lock_st[g]   <= lsa_pkg::LSA_HUNT;  // Forwarded clock stopped
        rx_lock_o[g] <= 1'b0;
      end
    end
  end

  // Per-channel bit phase: adds W per cycle modulo period, so W slots per period
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < lsa_pkg::CH_N; c++) begin  // [RULE5] [RULE11]
      logic [8:0] nxt;
      logic [8:0] half;
      nxt  = {1'b0, acc[c]} + {5'h00, mult_i};
      half = {2'b00, per[grp_of(c)][7:1]};
      if (reset_i || lock_st[grp_of(c)] != lsa_pkg::LSA_LOCKED || cfg_bad) begin
        acc[c]  <= '0;
        samp[c] <= 1'b0;
      end else if (train_i && (din_s2[c] ^ din_s3[c])) begin
        // Data edge marks a bit boundary; restarting at zero puts the P/2 crossing mid-bit
        acc[c]  <= '0;  // [RULE6] [RULE10]
        samp[c] <= 1'b0;
      end else begin
        acc[c]  <= (nxt >= {1'b0, per[grp_of(c)]}) ? 8'(nxt - {1'b0, per[grp_of(c)]}) : nxt[7:0];  // [RULE2]
        samp[c] <= ({1'b0, acc[c]} < half) && (nxt >= half);
      end
    end
  end

  // Shift, count and emit words; the training pattern sets the boundary in both modes
  // A forwarded-clock boundary cannot be centred through the sync pipeline, so it is not used here
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < lsa_pkg::CH_N; c++) begin
      logic [9:0] sn;
      logic       hit;
      sn  = {sr[c][8:0], din_s3[c]};
      hit = train_i && (deser_i >= lsa_pkg::FACT_LO) &&
            ((sn & ~(10'h3ff << deser_i)) == train_pat(deser_i));  // [RULE8]
      rx_valid_o[c] <= 1'b0;
      if (reset_i || cfg_bad || lock_st[grp_of(c)] != lsa_pkg::LSA_LOCKED) begin
        sr[c]           <= '0;
        bcnt[c]         <= '0;
        rx_word_o[c]    <= '0;
        rx_aligned_o[c] <= 1'b0;
      end else if (samp[c]) begin
        sr[c] <= sn;
        // Once trained, counting J samples keeps the boundary with the phase frozen
        if (hit || (bcnt[c] + 4'h1 == deser_i)) begin
          rx_word_o[c]  <= sn & ~(10'h3ff << deser_i);  // [RULE4]
          rx_valid_o[c] <= 1'b1;
          bcnt[c]       <= 4'h0;  // [RULE9]
          if (hit) begin
            rx_aligned_o[c] <= 1'b1;  // [RULE9] [RULE10]
          end
        end else begin
          bcnt[c] <= bcnt[c] + 4'h1;
        end
      end
    end
  end

  // Transmit clock generators: bit ticks, forwarded clock high for first half
  always_ff @(posedge clk_i) begin
    for (int g = 0; g < lsa_pkg::GRP_N; g++) begin  // [RULE12]
      tx_take_o[g] <= 1'b0;
      if (reset_i || cfg_bad) begin
        tdiv[g]      <= '0;
        twcnt[g]     <= '0;
        tccnt[g]     <= '0;
        tx_fclk_o[g] <= 1'b0;
      end else if (tdiv[g] == lsa_pkg::TX_DIV_END) begin
        tdiv[g]      <= '0;
        twcnt[g]     <= (twcnt[g] + 4'h1 == deser_i) ? 4'h0 : twcnt[g] + 4'h1;
        tccnt[g]     <= (tccnt[g] + 4'h1 == mult_i) ? 4'h0 : tccnt[g] + 4'h1;
        tx_fclk_o[g] <= (tccnt[g] < ((mult_i + 4'h1) >> 1));  // [RULE1]
        tx_take_o[g] <= (twcnt[g] == 4'h0);
      end else begin
        tdiv[g] <= tdiv[g] + 4'h1;
      end
    end
  end

  // Transmit shifters, MSB of the J-bit word first
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < lsa_pkg::CH_N; c++) begin
      if (reset_i || cfg_bad) begin
        tsr[c]       <= '0;
        tx_data_o[c] <= 1'b0;
      end else if (tdiv[grp_of(c)] == lsa_pkg::TX_DIV_END) begin
        if (twcnt[grp_of(c)] == 4'h0) begin
          tx_data_o[c] <= tx_word_i[c][deser_i - 4'h1];  // [RULE13]
          tsr[c]       <= tx_word_i[c] << 1;
        end else begin
          tx_data_o[c] <= tsr[c][deser_i - 4'h1];
          tsr[c]       <= tsr[c] << 1;
        end
      end
    end
  end

  // Checks on channel 0 and generator 0; the transmit cover watches generator 1
  cfg_check_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE3]
    !fact_ok(deser_i) |=> cfg_err_o) else $error("illegal factor not flagged");
  single_eq_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE7]
    (!multi_bit_i && mult_i != deser_i) |=> cfg_err_o && !tx_take_o[0]) else $error("unequal factors accepted");
  word_width_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE4]
    rx_valid_o[0] |-> (rx_word_o[0] >> deser_i) == 10'h000) else $error("word wider than factor");
  phase_range_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE2]
    rx_lock_o[0] && $stable(rx_lock_o[0]) |-> acc[0] < per[0]) else $error("phase out of period");
  lock_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE1]
    $rose(rx_lock_o[0]) |-> $past(frise[0])) else $error("lock without clock edge");
  resync_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE6]
    (train_i && (din_s2[0] ^ din_s3[0]) && lock_st[0] == lsa_pkg::LSA_LOCKED && !cfg_bad)
    |=> acc[0] == 8'h00) else $error("no resync on data edge");
  multi_align_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE10]
    (multi_bit_i && train_i && samp[0] && !cfg_bad && lock_st[0] == lsa_pkg::LSA_LOCKED && deser_i >= 4'h4
     && (({sr[0][8:0], din_s3[0]} & ~(10'h3ff << deser_i)) == train_pat(deser_i)))
    |=> rx_valid_o[0] && rx_aligned_o[0] && bcnt[0] == 4'h0) else $error("pattern not aligned");
  single_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE9]
    (!multi_bit_i && train_i && samp[0] && !cfg_bad && lock_st[0] == lsa_pkg::LSA_LOCKED
     && deser_i >= lsa_pkg::FACT_LO
     && (({sr[0][8:0], din_s3[0]} & ~(10'h3ff << deser_i)) == train_pat(deser_i)))
    |=> rx_valid_o[0] && rx_aligned_o[0] && bcnt[0] == 4'h0 && rx_word_o[0] == train_pat($past(deser_i)))
    else $error("boundary not on pattern");
  tx_first_a: assert property (@(posedge clk_i) disable iff (reset_i)  // [RULE13]
    tx_take_o[0] |-> tx_data_o[0] == $past(tx_word_i[0][deser_i - 4'h1])) else $error("tx not msb first");

  lock_c:   cover property (@(posedge clk_i) disable iff (reset_i) $rose(rx_lock_o[0]));
  align_c:  cover property (@(posedge clk_i) disable iff (reset_i) $rose(rx_aligned_o[0]));
  multi_c:  cover property (@(posedge clk_i) disable iff (reset_i) multi_bit_i && rx_valid_o[0] && mult_i != deser_i);
  tx_c:     cover property (@(posedge clk_i) disable iff (reset_i) tx_take_o[1] ##1 tx_fclk_o[1]);
endmodule : lsa_serdes
`default_nettype wire

// ==== lsa_far_end.sv ====
// Purpose: Far-end serial transmitter model driving forwarded clocks and data lanes.
// Assumes: Four bits per forwarded period of 64 ns, so 16 ns per bit.
// Notes:   Lanes lag the forwarded clock by a fixed skew; idle lanes toggle.
`timescale 1ns/100ps
`default_nettype none
module lsa_far_end (
  input  wire logic        en_i,
  input  wire logic [3:0]  word_i,
  output logic      [1:0]  fclk_o,
  output logic      [35:0] data_o
);
  localparam int BIT_NS  = 16;
  localparam int SKEW_NS = 5;  // Fixed lag, under half a bit
  logic [3:0] frame;
  // Whole frames only; the clock stands low and lanes toggle while idle
  initial begin
    fclk_o = '0;
    data_o = '0;
    frame  = '0;
    #3;
    forever begin
      if (en_i === 1'b1) begin
        frame = word_i;  // Latched so a frame never mixes two words
        for (int b = 3; b >= 0; b--) begin
          fclk_o = (b >= 2) ? 2'h3 : 2'h0;
          #SKEW_NS;
          data_o = {36{frame[b]}};
          #(BIT_NS - SKEW_NS);
        end
      end else begin
        fclk_o = '0;
        data_o = ~data_o;
        #8;
      end
    end
  end
endmodule : lsa_far_end
`default_nettype wire

// ==== test_lsa_serdes.sv ====
// Purpose: Self-checking bench for the serial skew/alignment block.
// Assumes: W = J = 4 in normal runs; forwarded period 64 ns.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module test_lsa_serdes;
  logic                                      clk_i, reset_i, multi_bit_i, train_i, far_en;
  logic [3:0]                                mult_i, deser_i, far_word;
  logic [1:0]                                rx_fclk_i, rx_lock_o, tx_take_o, tx_fclk_o;
  logic [lsa_pkg::CH_N-1:0]                  rx_data_i, rx_valid_o, rx_aligned_o, tx_data_o;
  logic [lsa_pkg::CH_N-1:0][lsa_pkg::DW-1:0] rx_word_o, tx_word_i;
  logic                                      cfg_err_o;
  int                                        num_errors, checked, cycles, n;
  lsa_serdes dut (.clk_i, .reset_i, .mult_i, .deser_i, .multi_bit_i, .train_i, .rx_fclk_i, .rx_data_i,
    .rx_word_o, .rx_valid_o, .rx_aligned_o, .rx_lock_o, .cfg_err_o, .tx_word_i, .tx_take_o, .tx_data_o, .tx_fclk_o);
  lsa_far_end far (.en_i(far_en), .word_i(far_word), .fclk_o(rx_fclk_i), .data_o(rx_data_i));
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic do_reset;
    reset_i = 1'b1;
    repeat (2) tick();
    reset_i = 1'b0;
  endtask : do_reset
  // Bounded wait for one word on a lane
  task automatic wait_rx(input int ch);
    n = 0;
    tick();
    while (rx_valid_o[ch] !== 1'b1 && n < 200) begin tick(); n++; end
    chk({9'h0, n < 200}, 10'h1);
  endtask : wait_rx
  // Legal and illegal factor sets, both modes
  task automatic t_cfg;
    logic [12:0] tab [6] = '{13'h0_4_5_1, 13'h0_3_3_1, 13'h0_b_b_1, 13'h1_4_8_0, 13'h1_1_2_0, 13'h0_a_a_0};
    foreach (tab[i]) begin
      {multi_bit_i, mult_i, deser_i} = tab[i][12:4];
      repeat (3) tick();
      chk({9'h0, cfg_err_o}, {9'h0, tab[i][0]});
    end
    {multi_bit_i, mult_i, deser_i} = 9'h0_4_4;
    do_reset();
  endtask : t_cfg
  // Transmit order, spacing and forwarded clock
  task automatic t_tx;
    n = 0;
    while (tx_take_o[1] !== 1'b1 && n < 100) begin tick(); n++; end
    chk({8'h0, tx_fclk_o}, 10'h3);
    for (int b = 3; b >= 0; b--) begin
      chk({7'h0, tx_data_o[35], tx_data_o[18], tx_data_o[0]}, {7'h0, {3{tx_word_i[18][b]}}});
      chk({8'h0, tx_fclk_o}, (b >= 2) ? 10'h3 : 10'h0);
      repeat (2) tick();
    end
    chk({8'h0, tx_take_o}, 10'h3);
  endtask : t_tx
  // Training lock, alignment and pattern word
  task automatic t_train;
    far_word = 4'h3;
    far_en   = 1'b1;
    train_i  = 1'b1;
    n = 0;
    while ((rx_lock_o !== 2'h3 || rx_aligned_o[35] !== 1'b1 || rx_aligned_o[0] !== 1'b1) && n < 600) begin
      tick();
      n++;
    end
    chk({9'h0, n < 600}, 10'h1);
    repeat (2) wait_rx(0);
    chk(rx_word_o[0], 10'h003);
  endtask : t_train
  // Payload after training with phase frozen
  task automatic t_data;
    train_i  = 1'b0;
    far_word = 4'ha;
    repeat (3) wait_rx(0);
    chk(rx_word_o[0], 10'h00a);
    chk(rx_word_o[35], 10'h00a);
    chk({9'h0, rx_aligned_o[35]}, 10'h1);
  endtask : t_data
  // Multi-bit mode: reset mid-run, relock and realign on the pattern
  task automatic t_multi;
    multi_bit_i = 1'b1;
    train_i     = 1'b1;
    far_word    = 4'h3;
    do_reset();
    n = 0;
    while (rx_aligned_o[0] !== 1'b1 && n < 600) begin
      tick();
      n++;
    end
    chk({9'h0, n < 600}, 10'h1);
    repeat (2) wait_rx(0);
    chk(rx_word_o[0], 10'h003);
    chk(rx_word_o[35], 10'h003);
  endtask : t_multi
  // Main sequence
  initial begin
    {reset_i, multi_bit_i, train_i, far_en} = 4'h8;
    {mult_i, deser_i, far_word} = 12'h440;
    tx_word_i = {lsa_pkg::CH_N{10'h00c}};
    num_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (2) tick();
    reset_i = 1'b0;
    chk({7'h0, cfg_err_o, rx_lock_o}, 10'h0);
    t_cfg();
    t_tx();
    t_train();
    t_data();
    t_multi();
    close_out();
  end
endmodule : test_lsa_serdes
`default_nettype wire
